// ### hdl/adc_seq_cfg.svh
// constants for the converter sequencer: register map, fields, reset values, timing
// assumes inclusion by the design modules and the bench by bare name
`ifndef ADC_SEQ_CFG_SVH
`define ADC_SEQ_CFG_SVH
`define OFF_STATUS_CONTROL 4'h0
`define OFF_RESULT_HIGH 4'h4
`define OFF_RESULT_LOW 4'h8
`define OFF_CONVERTER_CONTROL 4'hc
`define BIT_DONE 7
`define BIT_IRQ_EN 6
`define BIT_CONTINUOUS 5
`define BIT_POWER_UP 7
`define BIT_JUSTIFY_RIGHT 6
`define BIT_EIGHT_BIT 5
`define BIT_SIGNED 4
`define RST_STATUS_CONTROL 8'h1f
`define RST_CONVERTER_CONTROL 8'h00
`define CHAN_LAST_INPUT 5'h07
`define CHAN_HIGH_REF 5'h1e
`define SEL_LOW_REF 4'h8
`define SEL_HIGH_REF 4'h9
`define CONV_CLOCKS 5'h0e
`define AXI_OKAY 2'b00
`define AXI_SLVERR 2'b10
`endif

// ### hdl/adc_seq_pkg.sv
// types shared by the converter sequencer files
// assumes adc_seq_cfg.svh is on the include path
package adc_seq_pkg;
  typedef struct packed {
    logic [3:0] inputSelect;
    logic start;
  } conv_req_type;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_REQUEST = 2'b01,
    ST_WAIT = 2'b10
  } conv_state_type;
endpackage : adc_seq_pkg

// ### hdl/adc_sequencer.sv
// sequencer for a 10-bit successive-approximation converter, with AXI4-Lite registers
// assumes the analog core answers each start with one done pulse carrying the code
//
// Added by the designer: the AXI4-Lite slave port and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "adc_seq_cfg.svh"
module adc_sequencer
  import adc_seq_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output adc_seq_pkg::conv_req_type convReq_r,
  output logic convClock_r,
  output logic powerUp_r,
  input wire logic convDone,
  input wire logic [9:0] convCode,
  output logic irq_r
);
  import adc_seq_pkg::*;

  logic [7:0] statusCtrl_r;
  logic [7:0] convCtrl_r;
  logic doneFlag_r;
  logic [3:0] awAddr_r;
  logic [31:0] wData_r;
  logic [3:0] wStrb_r;
  logic awHeld_r;
  logic wHeld_r;
  logic [4:0] prescaleCount_r;
  logic [4:0] convCount_r;
  conv_state_type state_r;
  logic [7:0] resultHigh;
  logic [7:0] resultLow;
  logic writeFire;
  logic wrStatus;
  logic wrControl;
  logic readFire;
  logic rdResult;
  logic startConv;
  logic abortConv;
  logic [4:0] prescaleLimit;
  logic convTick;
  logic finishConv;
  logic [3:0] inputSel;
  logic [31:0] readData;
  logic [1:0] readResp;
  logic [4:0] channel;

  // write address and data may arrive in either order; each is held until both are here
  assign writeFire = awHeld_r && wHeld_r && !s_axi_bvalid;
  assign wrStatus = writeFire && (awAddr_r == `OFF_STATUS_CONTROL) && wStrb_r[0];
  assign wrControl = writeFire && (awAddr_r == `OFF_CONVERTER_CONTROL) && wStrb_r[0];
  assign readFire = s_axi_arvalid && s_axi_arready;
  assign rdResult = readFire &&
      (s_axi_araddr == `OFF_RESULT_HIGH || s_axi_araddr == `OFF_RESULT_LOW);
  assign channel = statusCtrl_r[4:0];
  assign startConv = wrStatus;
  assign abortConv = wrControl || !powerUp_r;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      awHeld_r <= 1'b0;
      awAddr_r <= 4'h0;
      s_axi_awready <= 1'b1;
    end else if (s_axi_awvalid && s_axi_awready) begin
      awHeld_r <= 1'b1;
      awAddr_r <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else if (writeFire) begin
      awHeld_r <= 1'b0;
    end else if (!awHeld_r && !s_axi_bvalid) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wHeld_r <= 1'b0;
      wData_r <= 32'h0;
      wStrb_r <= 4'h0;
      s_axi_wready <= 1'b1;
    end else if (s_axi_wvalid && s_axi_wready) begin
      wHeld_r <= 1'b1;
      wData_r <= s_axi_wdata;
      wStrb_r <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end else if (writeFire) begin
      wHeld_r <= 1'b0;
    end else if (!wHeld_r && !s_axi_bvalid) begin
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `AXI_OKAY;
    end else if (writeFire) begin
      s_axi_bvalid <= 1'b1;
      // result registers ignore writes; they answer okay, unmapped answers slverr
      s_axi_bresp <= (awAddr_r == `OFF_STATUS_CONTROL || awAddr_r == `OFF_RESULT_HIGH ||
          awAddr_r == `OFF_RESULT_LOW || awAddr_r == `OFF_CONVERTER_CONTROL) ?
          `AXI_OKAY : `AXI_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      statusCtrl_r <= `RST_STATUS_CONTROL;
    end else if (wrStatus) begin
      statusCtrl_r <= {1'b0, wData_r[6:0]};
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      convCtrl_r <= `RST_CONVERTER_CONTROL;
    end else if (wrControl) begin
      convCtrl_r <= wData_r[7:0];
    end
  end
  assign powerUp_r = convCtrl_r[`BIT_POWER_UP];

  always_comb begin
    readResp = `AXI_OKAY;
    case (s_axi_araddr)
      `OFF_STATUS_CONTROL: readData = {24'h0, doneFlag_r, statusCtrl_r[6:0]};
      `OFF_RESULT_HIGH: readData = {24'h0, resultHigh};
      `OFF_RESULT_LOW: readData = {24'h0, resultLow};
      `OFF_CONVERTER_CONTROL: readData = {24'h0, convCtrl_r};
      default: begin
        readData = 32'h0;
        readResp = `AXI_SLVERR;
      end
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `AXI_OKAY;
    end else if (readFire) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= readData;
      s_axi_rresp <= readResp;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // prescaler divides by 2*(field+1): half period is field+1 bus clocks
  assign prescaleLimit = {1'b0, convCtrl_r[3:0]};
  assign convTick = convClock_r && (prescaleCount_r == prescaleLimit);
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      prescaleCount_r <= 5'h0;
      convClock_r <= 1'b0;
    end else if (!powerUp_r || state_r == ST_IDLE) begin
      prescaleCount_r <= 5'h0;
      convClock_r <= 1'b0;
    end else if (prescaleCount_r == prescaleLimit) begin
      prescaleCount_r <= 5'h0;
      convClock_r <= ~convClock_r;
    end else begin
      prescaleCount_r <= prescaleCount_r + 5'h1;
    end
  end

  always_comb begin
    if (channel <= `CHAN_LAST_INPUT) begin
      inputSel = {1'b0, channel[2:0]};
    end else if (channel == `CHAN_HIGH_REF) begin
      inputSel = `SEL_HIGH_REF;
    end else begin
      inputSel = `SEL_LOW_REF;
    end
  end

  // a conversion ends on the core's done pulse or after a fixed count of conversion clocks
  assign finishConv = (state_r == ST_WAIT) && !abortConv &&
      (convDone || (convTick && convCount_r == `CONV_CLOCKS));

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= ST_IDLE;
      convCount_r <= 5'h0;
      convReq_r <= '0;
    end else begin
      convReq_r.start <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (startConv && powerUp_r) begin
            state_r <= ST_REQUEST;
          end
        end
        ST_REQUEST: begin
          if (abortConv) begin
            state_r <= ST_IDLE;
          end else begin
            convReq_r.start <= 1'b1;
            convReq_r.inputSelect <= inputSel;
            convCount_r <= 5'h0;
            state_r <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (startConv && !abortConv) begin
            state_r <= ST_REQUEST;
          end else if (abortConv) begin
            state_r <= ST_IDLE;
          end else if (finishConv) begin
            state_r <= statusCtrl_r[`BIT_CONTINUOUS] ? ST_REQUEST : ST_IDLE;
          end else if (convTick) begin
            convCount_r <= convCount_r + 5'h1;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // flag and results update together on the finishing edge
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      doneFlag_r <= 1'b0;
    end else if (finishConv) begin
      doneFlag_r <= 1'b1;
    end else if (wrStatus || rdResult) begin
      doneFlag_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= statusCtrl_r[`BIT_IRQ_EN] && doneFlag_r && !wrStatus && !rdResult;
    end
  end

  result_formatter formatter (
    .clk(clk),
    .sys_rst(sys_rst),
    .load(finishConv),
    .code(convCode),
    .justifyRight(convCtrl_r[`BIT_JUSTIFY_RIGHT]),
    .eightBit(convCtrl_r[`BIT_EIGHT_BIT]),
    .signedSel(convCtrl_r[`BIT_SIGNED]),
    .resultHigh_r(resultHigh),
    .resultLow_r(resultLow)
  );
endmodule : adc_sequencer
`default_nettype wire

// ### hdl/result_formatter.sv
// result formatter: maps a 10-bit code onto the high and low result bytes
// assumes the caller holds the control bits steady while the result is latched
`timescale 1ns/100ps
`default_nettype none
`include "adc_seq_cfg.svh"
module result_formatter (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic load,
  input wire logic [9:0] code,
  input wire logic justifyRight,
  input wire logic eightBit,
  input wire logic signedSel,
  output logic [7:0] resultHigh_r,
  output logic [7:0] resultLow_r
);
  logic [9:0] adjusted;
  logic [7:0] highNxt;
  logic [7:0] lowNxt;
  always_comb begin
    adjusted = code;
    // sign applies to left justification only; an 8-bit result with right set stays unsigned
    if (signedSel && !justifyRight) begin
      adjusted[9] = ~code[9];
    end
    if (eightBit) begin
      highNxt = adjusted[9:2];
      lowNxt = 8'h00;
    end else if (justifyRight) begin
      highNxt = {6'h00, adjusted[9:8]};
      lowNxt = adjusted[7:0];
    end else begin
      highNxt = adjusted[9:2];
      lowNxt = {adjusted[1:0], 6'h00};
    end
  end
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      resultHigh_r <= 8'h00;
      resultLow_r <= 8'h00;
    end else if (load) begin
      resultHigh_r <= highNxt;
      resultLow_r <= lowNxt;
    end
  end
endmodule : result_formatter
`default_nettype wire

// ### verif/adc_core_model.sv
// stand-in for the analog core: one done pulse with a code per start pulse
// assumes start is a one-cycle pulse; slow selects a long conversion
`timescale 1ns/100ps
`default_nettype none
module adc_core_model (
  input wire logic clk,
  input wire logic start,
  input wire logic slow,
  input wire logic [9:0] code,
  output logic convDone,
  output logic [9:0] convCode
);
  int cnt = -1;
  initial convDone = 1'h0;
  initial convCode = 10'h0;
  always @(posedge clk) begin
    convDone <= 1'h0;
    // code means nothing outside the done pulse, so it keeps changing
    convCode <= ~convCode;
    if (start) cnt <= slow ? 80 : 3;
    else if (cnt > 0) cnt <= cnt - 1;
    else if (cnt == 0) begin
      convDone <= 1'h1;
      convCode <= code;
      cnt <= -1;
    end
  end
endmodule : adc_core_model
`default_nettype wire

// ### verif/adc_sequencer_chk.sv
// port checker for the converter sequencer
// assumes it is bound into adc_sequencer
`timescale 1ns/100ps
`default_nettype none
module adc_sequencer_chk
  import adc_seq_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic s_axi_arready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire adc_seq_pkg::conv_req_type convReq_r,
  input wire logic convClock_r,
  input wire logic powerUp_r,
  input wire logic convDone,
  input wire logic irq_r
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  irq_source_a: assert property ($rose(irq_r) |-> $past(convDone, 2))
    else $error("irq rose without completion");
  irq_clear_a: assert property ($fell(irq_r) |-> s_axi_bvalid || s_axi_rvalid)
    else $error("irq fell unprompted");
  start_pulse_a: assert property (convReq_r.start |=> !convReq_r.start)
    else $error("start longer than one cycle");
  start_power_a: assert property (convReq_r.start |-> powerUp_r)
    else $error("start while powered down");
  clock_power_a: assert property (convClock_r |-> powerUp_r || $past(powerUp_r))
    else $error("conversion clock while powered down");
  done_gap_a: assert property (convDone |=> !convReq_r.start)
    else $error("restart before results");
  rdata_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits set");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  ar_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while busy");
endmodule : adc_sequencer_chk
bind adc_sequencer adc_sequencer_chk i_chk (.clk(clk), .sys_rst(sys_rst),
  .s_axi_arready(s_axi_arready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .convReq_r(convReq_r), .convClock_r(convClock_r), .powerUp_r(powerUp_r),
  .convDone(convDone), .irq_r(irq_r));
`default_nettype wire

// ### verif/adc_sequencer_result_format_test.sv
// self-checking bench: registers over AXI4-Lite, core stand-in on the far side
// assumes a 100 MHz bus clock, far above what any prescale keeps within 2 MHz
`timescale 1ns/100ps
`default_nettype none
`include "adc_seq_cfg.svh"
module adc_sequencer_result_format_test;
  import adc_seq_pkg::*;
  logic clk = 1'h0, sys_rst = 1'h1, slow = 1'h0, allowStart = 1'h0, contMode = 1'h0;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf, expSel = 4'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, convClock_r, powerUp_r, convDone, irq_r;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic [1:0] s_axi_bresp, s_axi_rresp, bq[$];
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [9:0] convCode, code = 10'h0;
  logic [34:0] rq[$];
  logic [15:0] e;
  logic [7:0] fmt, fmts [7] = '{8'h8f, 8'h9f, 8'hcf, 8'hdf, 8'haf, 8'hbf, 8'hff};
  logic [4:0] ch, chans [12] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07,
    5'h08, 5'h1d, 5'h1e, 5'h1f};
  conv_req_type convReq_r;
  int mismatches = 0, checks = 0, seed = 37, startCnt = 0, k, t, i;
  always #5 clk = ~clk;
  adc_sequencer i_dut (.clk(clk), .sys_rst(sys_rst), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .convReq_r(convReq_r), .convClock_r(convClock_r),
    .powerUp_r(powerUp_r), .convDone(convDone), .convCode(convCode), .irq_r(irq_r));
  adc_core_model i_core (.clk(clk), .start(convReq_r.start), .slow(slow), .code(code),
    .convDone(convDone), .convCode(convCode));
  function automatic logic [15:0] fmtRes(input logic [9:0] c, input logic [7:0] f);
    c[9] = c[9] ^ (f[4] & !f[6]);
    if (f[5]) return {c[9:2], 8'h0};
    if (!f[6]) return {c[9:2], c[1:0], 6'h0};
    return {6'h0, c};
  endfunction : fmtRes
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic results();
    if (mismatches == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : results
  task automatic over(input int n, input int lim);
    if (n >= lim) begin
      mismatches++;
      results();
    end
  endtask : over
  task automatic wr(input logic [3:0] a, input logic [7:0] v, input logic [1:0] r);
    int n = 0;
    bq.push_back(r);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, v};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid && n < 50);
    s_axi_bready <= 1'h0;
    over(n, 50);
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] v, input logic c,
                    output logic [31:0] q);
    int n = 0;
    logic [1:0] r;
    // only word-aligned offsets are mapped in the 4-bit address space
    r = (a[1:0] == 2'h0) ? `AXI_OKAY : `AXI_SLVERR;
    rq.push_back({r, c, 24'h0, v});
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid && n < 50);
    q = s_axi_rdata;
    s_axi_rready <= 1'h0;
    over(n, 50);
  endtask : rd
  task automatic hold(input logic lv, inout int n);
    while (convClock_r === lv && n < 300) begin
      @(posedge clk);
      n++;
    end
  endtask : hold
  // results are compared where they appear, against the oldest note
  always @(posedge clk) begin
    if (s_axi_rvalid && s_axi_rready && rq.size() > 0) begin
      if (rq[0][32]) chk(s_axi_rdata, rq[0][31:0]);
      chk(s_axi_rresp, rq[0][34:33]);
      void'(rq.pop_front());
    end
    if (s_axi_bvalid && s_axi_bready && bq.size() > 0) chk(s_axi_bresp, bq.pop_front());
    if (convReq_r.start) begin
      startCnt++;
      chk({1'h1, convReq_r.inputSelect}, {allowStart, expSel});
      if (!contMode) allowStart = 1'h0;
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    sys_rst <= 1'h0;
    rd(`OFF_STATUS_CONTROL, 8'h1f, 1'h1, d);
    rd(`OFF_CONVERTER_CONTROL, 8'h00, 1'h1, d);
    wr(`OFF_STATUS_CONTROL, 8'h05, `AXI_OKAY);
    wr(4'h2, 8'h00, `AXI_SLVERR);
    rd(4'h2, 8'h00, 1'h1, d);
    for (i = 0; i < 12; i++) begin
      ch = chans[i];
      fmt = fmts[i % 7];
      code <= 10'($random(seed));
      slow <= (i == 0) | 1'($random(seed));
      wr(`OFF_CONVERTER_CONTROL, fmt, `AXI_OKAY);
      expSel = ch < 5'h08 ? ch[3:0] : (ch == 5'h1e ? 4'h9 : 4'h8);
      allowStart = 1'h1;
      wr(`OFF_STATUS_CONTROL, {3'h0, ch}, `AXI_OKAY);
      if (i == 0) begin
        k = 0;
        hold(1'h0, k);
        k = 0;
        hold(1'h1, k);
        hold(1'h0, k);
        chk(k, 32);
      end
      k = 0;
      do rd(`OFF_STATUS_CONTROL, 8'h00, 1'h0, d); while (!d[7] && ++k < 100);
      over(k, 100);
      rd(`OFF_STATUS_CONTROL, {3'h4, ch}, 1'h1, d);
      e = fmtRes(code, fmt);
      rd(`OFF_RESULT_HIGH, e[15:8], 1'h1, d);
      rd(`OFF_STATUS_CONTROL, {3'h0, ch}, 1'h1, d);
      wr(`OFF_RESULT_LOW, 8'hff, `AXI_OKAY);
      rd(`OFF_RESULT_LOW, e[7:0], 1'h1, d);
    end
    contMode = 1'h1;
    allowStart = 1'h1;
    slow <= 1'h1;
    expSel = 4'h3;
    code <= 10'($random(seed));
    wr(`OFF_STATUS_CONTROL, 8'h63, `AXI_OKAY);
    k = startCnt;
    t = 0;
    while (startCnt < k + 3 && t++ < 1000) @(posedge clk);
    over(t, 1000);
    chk(irq_r, 1'h1);
    e = fmtRes(code, fmt);
    rd(`OFF_RESULT_HIGH, e[15:8], 1'h1, d);
    repeat (2) @(posedge clk);
    chk(irq_r, 1'h0);
    code <= 10'($random(seed));
    t = 0;
    while (irq_r !== 1'h1 && t++ < 300) @(posedge clk);
    over(t, 300);
    e = fmtRes(code, fmt);
    rd(`OFF_RESULT_HIGH, e[15:8], 1'h1, d);
    wr(`OFF_CONVERTER_CONTROL, fmt, `AXI_OKAY);
    allowStart = 1'h0;
    contMode = 1'h0;
    repeat (300) @(posedge clk);
    expSel = 4'h3;
    allowStart = 1'h1;
    wr(`OFF_STATUS_CONTROL, 8'h43, `AXI_OKAY);
    t = 0;
    while (irq_r !== 1'h1 && t++ < 300) @(posedge clk);
    over(t, 300);
    sys_rst <= 1'h1;
    repeat (2) @(posedge clk);
    chk(irq_r, 1'h0);
    results();
  end
endmodule : adc_sequencer_result_format_test
`default_nettype wire
